// ===== bench/host_bridge_control_tb.sv
// Self-checking bench for the host bridge control block
`default_nettype none
module host_bridge_control_tb;
    import host_bridge_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, regWrite = 0, regRead = 0, portReady, portAbort, strobe_n;
    logic abortReq = 0;
    logic [7:0] regAddr = 8'h00, readyDelay = 8'h01;
    logic [31:0] regWdata = 32'h0, regRdata, initRdata, portWdata, portRdata, wd = 32'h0;
    logic [2:0] initRequest = 3'h0, initWide = 3'h7, initGrant, initDone, initAbort;
    logic [1:0] tgt = TGT_RAM, sharingModeSelect = 2'h0, portTarget;
    logic abrt;
    logic [31:0] pw;
    logic [1:0] pt;
    int n_errors = 0, checks = 0, lowCnt = 0, took = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (strobe_n === 1'b0) lowCnt++;
    host_bridge_control host_bridge_control_inst (.ref_clk(ref_clk), .rst(rst),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .initRequest(initRequest), .initTarget0(tgt), .initTarget1(tgt),
        .initTarget2(tgt), .initWdata0(wd), .initWdata1(wd), .initWdata2(wd),
        .initWide(initWide), .initGrant(initGrant), .initDone(initDone),
        .initAbort(initAbort), .initRdata(initRdata), .sharingModeSelect(sharingModeSelect),
        .strobe_n(strobe_n), .portTarget(portTarget), .portWdata(portWdata),
        .portRdata(portRdata), .portReady(portReady), .portAbort(portAbort));
    port_model port_model_inst (.ref_clk(ref_clk), .rst(rst), .strobe_n(strobe_n),
        .readyDelay(readyDelay), .abortReq(abortReq), .portReady(portReady),
        .portAbort(portAbort), .portRdata(portRdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] mk(input logic [1:0] ws, input logic [2:0] pr,
        input logic [1:0] bs, input logic [7:0] to, input logic [3:0] fac,
        input logic fwd, input logic ten);
        mk = {9'h000, ws, pr, bs, to, fac, fwd, 1'b1, ten, 1'b1};
    endfunction : mk
    function automatic logic [31:0] sw(input logic [31:0] d, input logic h, input logic b,
        input logic w);
        sw = (w && (h || b)) ? {d[15:0], d[31:16]} : d;
        if (b) sw = {sw[23:16], sw[31:24], sw[7:0], sw[15:8]};
    endfunction : sw
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) #2 {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(posedge ref_clk) #2 regWrite = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk) #2 {regRead, regAddr} = {1'b1, a};
        #1 chk(regRdata, exp);
        @(posedge ref_clk) #2 regRead = 0;
    endtask : rd
    // One transfer by initiator i; notes the port data at the strobe and the outcome
    task automatic xfer(input int i);
        logic seen;
        int k;
        seen = 0;
        @(posedge ref_clk) #2 initRequest[i] = 1'b1;
        lowCnt = 0;
        for (k = 0; k < 700 && initDone[i] !== 1'b1; k++)
        begin
            @(posedge ref_clk) #2;
            if (strobe_n === 1'b0 && !seen) {seen, pw, pt} = {1'b1, portWdata, portTarget};
        end
        took = k;
        chk(initDone[i], 1'b1);
        abrt = initAbort[i];
        initRequest[i] = 0;
        repeat (3) @(posedge ref_clk);
    endtask : xfer
    task automatic test_regs;
        rd(8'h00, CONTROL_RESET);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, CONTROL_WRITABLE | CONTROL_RESET);
        wr(8'h00, 32'h0);
        rd(8'h00, CONTROL_RESET & ~CONTROL_WRITABLE);
        rd(8'h04, 32'h0);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_swap;
        logic h, b, ram, w;
        for (int n = 0; n < 64; n++)
        begin
            wr(8'h00, mk(n[1:0], 3'h0, n[3:2], 8'hff, 4'h1, 1'b1, 1'b1));
            {tgt, wd, ram, w} = {n[4] ? TGT_PERIPH : TGT_RAM, 32'ha1b2_c3d4, !n[4], !n[5]};
            initWide = {3{w}};
            h = n[1:0] == 0 || (n[1:0] == 1 && !ram) || (n[1:0] == 2 && ram);
            b = n[3:2] == 2 || (n[3:2] == 1 && !ram) || (n[3:2] == 3 && ram);
            xfer(0);
            chk(pw, sw(wd, h, b, w));
            chk(initRdata, sw(32'h1122_3344, h, b, w));
            chk({30'h0, pt}, {30'h0, tgt});
        end
        initWide = 3'h7;
        $display("test_swap done");
    endtask : test_swap
    task automatic test_prio;
        logic [2:0] win [8] = '{3'h1, 3'h1, 3'h2, 3'h4, 3'h2, 3'h4, 3'h2, 3'h4};
        for (int p = 0; p < 8; p++)
        begin
            wr(8'h00, mk(2'h3, p[2:0], 2'h0, 8'hff, 4'h1, 1'b1, 1'b1));
            @(posedge ref_clk) #2 initRequest = 3'h7;
            for (int k = 0; k < 20 && initGrant === 3'h0; k++) @(posedge ref_clk) #2;
            chk(initGrant, win[p]);
            for (int k = 0; k < 40 && initDone === 3'h0; k++) @(posedge ref_clk) #2;
            initRequest = 0;
            repeat (3) @(posedge ref_clk);
        end
        $display("test_prio done");
    endtask : test_prio
    task automatic test_timing;
        {tgt, sharingModeSelect, readyDelay} = {TGT_PERIPH, 2'h1, 8'hff};
        wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'h05, 4'h1, 1'b0, 1'b1));
        xfer(0);
        chk(abrt, 1'b1);
        chk(lowCnt <= 12, 1'b1);
        chk(took >= 6 && took <= 9, 1'b1);
        readyDelay = 8'h14;
        wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'h05, 4'h1, 1'b0, 1'b0));
        xfer(1);
        chk(abrt, 1'b0);
        chk(took > 20, 1'b1);
        {tgt, sharingModeSelect} = {TGT_RAM, 2'h3};
        wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'h05, 4'h8, 1'b0, 1'b1));
        xfer(2);
        chk(abrt, 1'b0);
        readyDelay = 8'h00;
        xfer(0);
        chk(lowCnt, 8);
        wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'h05, 4'h0, 1'b0, 1'b1));
        xfer(0);
        chk(lowCnt, 1);
        sharingModeSelect = 2'h0;
        wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'h05, 4'hf, 1'b0, 1'b1));
        xfer(0);
        chk(lowCnt, 1);
        $display("test_timing done");
    endtask : test_timing
    task automatic test_port_abort;
        abortReq = 1;
        for (int f = 0; f < 2; f++)
        begin
            wr(8'h00, mk(2'h3, 3'h0, 2'h0, 8'hff, 4'h1, f[0], 1'b1));
            xfer(1);
            chk(abrt, f[0]);
        end
        abortReq = 0;
        $display("test_port_abort done");
    endtask : test_port_abort
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        #400000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #2 rst = 0;
        test_regs();
        test_swap();
        test_prio();
        test_timing();
        test_port_abort();
        end_of_test();
    end
endmodule : host_bridge_control_tb
`default_nettype wire

// ===== bench/port_model.sv
// Far-side port model with programmable ready delay and abort
`default_nettype none
module port_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic strobe_n,
    input wire logic [7:0] readyDelay,
    input wire logic abortReq,
    output logic portReady,
    output logic portAbort,
    output logic [31:0] portRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] waited;
    logic [1:0] held;
    logic active;
    logic busy;
    // An access outlives a short strobe until ready has stood three edges,
    // so the answer survives the bridge's two sync flops
    assign busy = active || !strobe_n;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            active <= 1'b0;
            waited <= 8'h00;
            held <= 2'h0;
        end
        else
        begin
            if (!strobe_n)
                active <= 1'b1;
            else if (held == 2'h3 || readyDelay == 8'hff)
                active <= 1'b0;
            // Counter saturates so a stuck strobe cannot wrap into a late answer
            waited <= busy ? waited + {7'h00, waited != 8'hff} : 8'h00;
            held <= portReady ? held + {1'b0, held != 2'h3} : 2'h0;
        end
    end
    // Delay 8'hff never answers, which is how the time-out is provoked
    assign portReady = busy && readyDelay != 8'hff && waited >= readyDelay;
    assign portAbort = portReady && abortReq;
    // Idle data differs from the answer so stale reads are caught
    assign portRdata = portReady ? 32'h1122_3344 : 32'heedd_ccbb;
endmodule : port_model
`default_nettype wire

// ===== hdl/bridge_arbiter.sv
// Fixed-priority arbiter among the three initiators
`default_nettype none
module bridge_arbiter
    import host_bridge_pkg::*;
(
    input wire logic [2:0] prioSel,
    input wire logic [2:0] request,
    output logic [2:0] grant
);
    logic [1:0] first;
    logic [1:0] second;
    logic [1:0] third;
    // Highest first
    assign first = prioSel[2] ? (prioSel[0] ? INIT_OCP : INIT_DMA)
                 : (prioSel[1:0] == 2'h0 || prioSel[1:0] == 2'h1) ? INIT_CORE
                 : prioSel[0] ? INIT_OCP : INIT_DMA;
    assign second = prioSel[2] ? (prioSel[0] ? INIT_DMA : INIT_OCP)
                  : (prioSel[1:0] == 2'h0) ? INIT_DMA
                  : (prioSel[1:0] == 2'h1) ? INIT_OCP : INIT_CORE;
    assign third = prioSel[2] ? INIT_CORE
                 : (prioSel[1:0] == 2'h0 || prioSel[1:0] == 2'h2) ? INIT_OCP : INIT_DMA;
    assign grant = request[first] ? (3'h1 << first)
                 : request[second] ? (3'h1 << second)
                 : request[third] ? (3'h1 << third) : 3'h0;
endmodule : bridge_arbiter
`default_nettype wire

// ===== hdl/host_bridge_control.sv
// Host bridge control: register, arbitration, swapping, strobe and time-out
`default_nettype none
module host_bridge_control
    import host_bridge_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic [2:0] initRequest,
    input wire logic [1:0] initTarget0,
    input wire logic [1:0] initTarget1,
    input wire logic [1:0] initTarget2,
    input wire logic [31:0] initWdata0,
    input wire logic [31:0] initWdata1,
    input wire logic [31:0] initWdata2,
    input wire logic [2:0] initWide,
    output logic [2:0] initGrant,
    output logic [2:0] initDone,
    output logic [2:0] initAbort,
    output logic [31:0] initRdata,
    input wire logic [1:0] sharingModeSelect,
    output logic strobe_n,
    output logic [1:0] portTarget,
    output logic [31:0] portWdata,
    input wire logic [31:0] portRdata,
    input wire logic portReady,
    input wire logic portAbort
);
    logic [31:0] control;
    bridge_state_t state;
    logic [2:0] owner;
    logic [1:0] target;
    logic wide;
    logic hostOnly;
    logic [3:0] stretch;
    logic [7:0] timer;
    logic timing;
    logic readySync1;
    logic readySync;
    logic abortSync1;
    logic abortSync;
    logic [2:0] grant;
    logic [1:0] selTarget;
    logic [31:0] selWdata;
    logic selWide;
    logic selHostOnly;
    logic [3:0] factor;
    logic timeoutHit;
    logic portAbortFwd;
    logic [31:0] swappedOut;
    logic [31:0] swappedIn;

    // Port handshake comes from the DSP side, another domain
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            readySync1 <= 1'b0;
            readySync <= 1'b0;
            abortSync1 <= 1'b0;
            abortSync <= 1'b0;
        end
        else
        begin
            readySync1 <= portReady;
            readySync <= readySync1;
            abortSync1 <= portAbort;
            abortSync <= abortSync1;
        end
    end

    function automatic logic [31:0] swap_word(input logic [31:0] d, input logic [1:0] tgt,
        input logic isWide, input logic [31:0] ctl);
        logic half;
        logic bytes;
        logic [31:0] r;
        // Swap selection per target
        unique case (ctl[HALF_SWAP_HI:HALF_SWAP_LO])
            2'h0: half = 1'b1;
            2'h1: half = (tgt == TGT_PERIPH);
            2'h2: half = (tgt == TGT_RAM);
            2'h3: half = 1'b0;
        endcase
        unique case (ctl[BYTE_SWAP_HI:BYTE_SWAP_LO])
            2'h0: bytes = 1'b0;
            2'h1: bytes = (tgt == TGT_PERIPH);
            2'h2: bytes = 1'b1;
            2'h3: bytes = (tgt == TGT_RAM);
        endcase
        r = d;
        // Byte swap implies a half exchange first on words
        if (isWide && (half || bytes))
            r = {r[15:0], r[31:16]};
        if (bytes)
            r = {r[23:16], r[31:24], r[7:0], r[15:8]};
        return r;
    endfunction : swap_word

    bridge_arbiter bridge_arbiter_inst (
        .prioSel(control[PRIO_HI:PRIO_LO]),
        .request(initRequest),
        .grant(grant)
    );
    onehot_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot0(grant))
        else $error("grant not one-hot");

    assign selTarget = grant[0] ? initTarget0 : grant[1] ? initTarget1 : initTarget2;
    assign selWdata = grant[0] ? initWdata0 : grant[1] ? initWdata1 : initWdata2;
    assign selWide = |(grant & initWide);
    // Host-only per resource
    assign selHostOnly = (selTarget == TGT_RAM) ? sharingModeSelect[1]
                       : (selTarget == TGT_PERIPH) ? sharingModeSelect[0] : 1'b0;
    // Factor zero acts as one; shared mode is never stretched
    assign factor = (!selHostOnly || control[FACTOR_HI:FACTOR_LO] == 4'h0) ? FACTOR_MIN
                  : control[FACTOR_HI:FACTOR_LO];
    // Only host-only peripheral accesses time out, and only when enabled
    assign timeoutHit = timing && control[TIMEOUT_EN_BIT] && timer == 8'h00;
    assign portAbortFwd = abortSync && control[ABORT_FWD_BIT];
    assign swappedOut = swap_word(selWdata, selTarget, selWide, control);
    assign swappedIn = swap_word(portRdata, target, wide, control);
    assign regRdata = (regRead && regAddr == BRIDGE_CONTROL_OFFSET) ? control : 32'h0;
    assign initGrant = owner;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            control <= CONTROL_RESET;
        else if (regWrite && regAddr == BRIDGE_CONTROL_OFFSET)
            // Reserved bits keep reset value
            control <= (regWdata & CONTROL_WRITABLE) | (CONTROL_RESET & ~CONTROL_WRITABLE);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            owner <= 3'h0;
            target <= 2'h0;
            wide <= 1'b0;
            hostOnly <= 1'b0;
            stretch <= 4'h0;
            timer <= 8'h00;
            timing <= 1'b0;
            strobe_n <= 1'b1;
            portTarget <= 2'h0;
            portWdata <= 32'h0;
            initDone <= 3'h0;
            initAbort <= 3'h0;
            initRdata <= 32'h0;
        end
        else
        begin
            initDone <= 3'h0;
            initAbort <= 3'h0;
            unique case (state)
                ST_IDLE:
                begin
                    if (|grant)
                    begin
                        owner <= grant;
                        target <= selTarget;
                        wide <= selWide;
                        hostOnly <= selHostOnly;
                        stretch <= factor;
                        timer <= control[TIMEOUT_HI:TIMEOUT_LO];
                        timing <= selHostOnly && selTarget == TGT_PERIPH;
                        strobe_n <= 1'b0;
                        portTarget <= selTarget;
                        portWdata <= swappedOut;
                        state <= ST_STROBE;
                    end
                end
                ST_STROBE, ST_WAIT:
                begin
                    if (timing && timer != 8'h00)
                        timer <= timer - 8'h01;
                    if (stretch > 4'h1)
                        stretch <= stretch - 4'h1;
                    else
                        strobe_n <= 1'b1;
                    if (timeoutHit || abortSync)
                    begin
                        // Own aborts always pass; port aborts only if forwarded
                        initAbort <= (timeoutHit || portAbortFwd) ? owner : 3'h0;
                        initDone <= owner;
                        strobe_n <= 1'b1;
                        state <= ST_DONE;
                    end
                    else if (readySync && stretch <= 4'h1)
                    begin
                        initRdata <= swappedIn;
                        initDone <= owner;
                        strobe_n <= 1'b1;
                        state <= ST_DONE;
                    end
                    else
                        state <= ST_WAIT;
                end
                ST_DONE:
                begin
                    // Wait for the synced answer to fall, so a stale ready cannot end the next one
                    if (!readySync && !abortSync)
                    begin
                        owner <= 3'h0;
                        timing <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    timeout_abort_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state != ST_IDLE && state != ST_DONE && timeoutHit) |=> (initAbort == owner))
        else $error("time-out did not abort");
    no_timeout_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !control[TIMEOUT_EN_BIT] |-> !timeoutHit)
        else $error("time-out while disabled");
    port_abort_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_WAIT && abortSync && !control[ABORT_FWD_BIT] && !timeoutHit)
        |=> initAbort == 3'h0)
        else $error("masked port abort forwarded");
    shared_no_time_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state != ST_IDLE && (!hostOnly || target != TGT_PERIPH)) |-> !timing)
        else $error("time-out armed outside host-only peripheral");
    shared_short_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_IDLE && |grant && !selHostOnly) |=> stretch == FACTOR_MIN)
        else $error("shared access stretched");
    reserved_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        ((control & ~CONTROL_WRITABLE) == (CONTROL_RESET & ~CONTROL_WRITABLE)))
        else $error("reserved bit changed");
    strobe_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_IDLE && |grant) |=> !strobe_n)
        else $error("strobe not low at start");
    strobe_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        ((state == ST_STROBE || state == ST_WAIT) && stretch > 4'h1
        && !timeoutHit && !abortSync) |=> !strobe_n)
        else $error("strobe shorter than factor");
    done_onehot_a: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot0(initDone))
        else $error("done to several initiators");
endmodule : host_bridge_control
`default_nettype wire

// ===== pkg/host_bridge_pkg.sv
// Constants and types for the host bridge control block
`default_nettype none
package host_bridge_pkg;
    localparam logic [7:0] BRIDGE_CONTROL_OFFSET = 8'h00;
    localparam int HALF_SWAP_HI = 22;
    localparam int HALF_SWAP_LO = 21;
    localparam int PRIO_HI = 20;
    localparam int PRIO_LO = 18;
    localparam int BYTE_SWAP_HI = 17;
    localparam int BYTE_SWAP_LO = 16;
    localparam int TIMEOUT_HI = 15;
    localparam int TIMEOUT_LO = 8;
    localparam int FACTOR_HI = 7;
    localparam int FACTOR_LO = 4;
    localparam int ABORT_FWD_BIT = 3;
    localparam int TIMEOUT_EN_BIT = 1;
    localparam logic [31:0] CONTROL_RESET = 32'h0003_ff1f;
    localparam logic [31:0] CONTROL_WRITABLE = 32'h007f_fffa;
    localparam logic [3:0] FACTOR_MIN = 4'h1;
    // Target select
    localparam logic [1:0] TGT_RAM = 2'h1;
    localparam logic [1:0] TGT_PERIPH = 2'h2;
    // Initiator indices
    localparam logic [1:0] INIT_CORE = 2'h0;
    localparam logic [1:0] INIT_DMA = 2'h1;
    localparam logic [1:0] INIT_OCP = 2'h2;
    typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_WAIT, ST_DONE} bridge_state_t;
endpackage : host_bridge_pkg
`default_nettype wire
